// File: logic/dma_defines.svh
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH

// Register offsets (byte addresses)
`define DMA_OFF_CTRL 8'h00
`define DMA_OFF_REQ 8'h04
`define DMA_OFF_SRC 8'h08
`define DMA_OFF_DST 8'h0c
`define DMA_OFF_RELOAD 8'h10
`define DMA_OFF_FWD 8'h14
`define DMA_OFF_COUNT 8'h18
`define DMA_OFF_SWTRIG 8'h1c
`define DMA_OFF_STATUS 8'h20
`define DMA_OFF_MASK 8'h24

// Control register fields
`define DMA_CTRL_EN 0
`define DMA_CTRL_UNIT 1
`define DMA_CTRL_SRCFWD 2
`define DMA_CTRL_EXTRISE 3
`define DMA_CTRL_TRIG_LO 8
`define DMA_CTRL_TRIG_HI 11

// Trigger select codes
`define DMA_TRIG_EXT 4'he
`define DMA_TRIG_SW 4'hf

// Status bits
`define DMA_STS_UNIT 0
`define DMA_STS_END 1

// Cycle coefficients per memory type
`define DMA_COEF_FAST 3'h1
`define DMA_COEF_WAIT 3'h2
`define DMA_COEF_MUX 3'h3

// Reset values
`define DMA_RST_CTRL 32'h0000_0000
`define DMA_RST_PTR 32'h0000_0000

`endif

// File: logic/dma_pkg.sv
package dma_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_GRANT = 2'b01,
        ST_READ  = 2'b11,
        ST_WRITE = 2'b10
    } dma_state_t;

    typedef enum logic [1:0] {
        MEM_FAST = 2'b00,
        MEM_WAIT = 2'b01,
        MEM_MUX  = 2'b10
    } mem_type_t;

endpackage

// File: logic/dma_transfer_request_control.sv
`timescale 1ns/1ps
`include "dma_defines.svh"

module dma_transfer_request_control import dma_pkg::*; #(
    parameter int NPERIPH = 12,
    parameter int AW = 20,
    parameter int CW = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Trigger sources
    input wire logic [NPERIPH-1:0] periph_irq_set,
    input wire logic external_irq_input_zero,
    // Memory bus
    input wire logic bus_grant,
    input wire logic bus_is_8bit,
    input wire logic [1:0] rd_mem_type,
    input wire logic [1:0] wr_mem_type,
    input wire logic [15:0] mem_rdata,
    output logic bus_req,
    output logic [AW-1:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [15:0] mem_wdata,
    // Interrupt
    output logic irq
);

    dma_state_t state_q;
    logic en_q, unit_byte_q, src_fwd_q, ext_rise_q, reload_pend_q, req_q, ext_prev_q;
    logic [3:0] trig_sel_q;
    logic [AW-1:0] src_q, dst_q, fwd_q, wr_a_q, reload_src, fwd_use, rd_base, wr_base;
    logic [CW-1:0] reload_q, cnt_q;
    logic [2:0] ph_q, rd_exp_q;
    logic [1:0] sts_q, mask_q;
    logic ctrl_wr, en_write, req_wr, start, ext_edge, trig_evt, unit_end, done;
    logic [2:0] rd_len, wr_len;
    logic [AW-1:0] step;

    function automatic logic [2:0] unit_len(input logic byte_u, input logic bus8,
                                            input logic odd, input logic [1:0] mt);
        logic [2:0] n;
        logic [2:0] j;
        n = (byte_u || !(bus8 || odd)) ? 3'h1 : 3'h2;
        case (mt)
            MEM_WAIT: j = `DMA_COEF_WAIT;
            MEM_MUX: j = `DMA_COEF_MUX;
            default: j = `DMA_COEF_FAST;
        endcase
        return 3'(n * j);
    endfunction

    assign ctrl_wr = reg_wr && reg_addr == `DMA_OFF_CTRL;
    assign en_write = ctrl_wr && reg_wdata[`DMA_CTRL_EN];
    assign req_wr = reg_wr && reg_addr == `DMA_OFF_REQ;
    assign start = state_q == ST_GRANT && bus_grant && en_q && req_q;
    assign unit_end = state_q == ST_WRITE && ph_q == 3'h0;
    assign done = unit_end && cnt_q <= CW'(1);
    assign reload_src = src_fwd_q ? src_q : dst_q;
    assign fwd_use = reload_pend_q ? reload_src : fwd_q;
    assign rd_base = src_fwd_q ? fwd_use : src_q;
    assign wr_base = src_fwd_q ? dst_q : fwd_use;
    assign rd_len = unit_len(unit_byte_q, bus_is_8bit, rd_base[0], rd_mem_type);
    assign wr_len = unit_len(unit_byte_q, bus_is_8bit, wr_base[0], wr_mem_type);
    assign step = unit_byte_q ? AW'(1) : AW'(2);

    // Selected edge of the external input
    assign ext_edge = ext_rise_q ? (external_irq_input_zero && !ext_prev_q)
                                 : (!external_irq_input_zero && ext_prev_q);

    always_comb begin
        case (trig_sel_q)
            `DMA_TRIG_SW: trig_evt = reg_wr && reg_addr == `DMA_OFF_SWTRIG && reg_wdata[0];
            `DMA_TRIG_EXT: trig_evt = ext_edge;
            default: trig_evt = (32'(trig_sel_q) < NPERIPH) &&
                                periph_irq_set[trig_sel_q];
        endcase
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            ext_prev_q <= 1'b1;
        end else begin
            ext_prev_q <= external_irq_input_zero;
        end
    end

    // Control and pointer registers
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            unit_byte_q <= 1'b0;
            src_fwd_q <= 1'b0;
            ext_rise_q <= 1'b0;
            trig_sel_q <= 4'h0;
            src_q <= '0;
            dst_q <= '0;
            reload_q <= '0;
            mask_q <= 2'h0;
        end else if (reg_wr) begin
            case (reg_addr)
                `DMA_OFF_CTRL: begin
                    unit_byte_q <= reg_wdata[`DMA_CTRL_UNIT];
                    src_fwd_q <= reg_wdata[`DMA_CTRL_SRCFWD];
                    ext_rise_q <= reg_wdata[`DMA_CTRL_EXTRISE];
                    trig_sel_q <= reg_wdata[`DMA_CTRL_TRIG_HI:`DMA_CTRL_TRIG_LO];
                end
                `DMA_OFF_SRC: src_q <= reg_wdata[AW-1:0];
                `DMA_OFF_DST: dst_q <= reg_wdata[AW-1:0];
                `DMA_OFF_RELOAD: reload_q <= reg_wdata[CW-1:0];
                `DMA_OFF_MASK: mask_q <= reg_wdata[1:0];
                default: ;
            endcase
        end
    end

    // Enable bit and pending reload
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            en_q <= 1'b0;
            reload_pend_q <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                en_q <= reg_wdata[`DMA_CTRL_EN];
            end else if (done) begin
                en_q <= 1'b0;
            end
            if (en_write) begin
                reload_pend_q <= 1'b1;
            end else if (start) begin
                reload_pend_q <= 1'b0;
            end
        end
    end

    // Request flag: a trigger wins over any clear in the same cycle
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            req_q <= 1'b0;
        end else if (trig_evt) begin
            req_q <= 1'b1;
        end else if (start || (req_wr && !reg_wdata[0])) begin
            req_q <= 1'b0;
        end
    end

    // Transfer sequencer
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            bus_req <= 1'b0;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= 16'h0000;
            wr_a_q <= '0;
            ph_q <= 3'h0;
            rd_exp_q <= 3'h0;
            fwd_q <= '0;
            cnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (en_q && req_q) begin
                        state_q <= ST_GRANT;
                        bus_req <= 1'b1;
                    end
                end
                ST_GRANT: begin
                    if (!(en_q && req_q)) begin
                        state_q <= ST_IDLE;
                        bus_req <= 1'b0;
                    end else if (start) begin
                        state_q <= ST_READ;
                        bus_req <= 1'b0;
                        mem_rd <= 1'b1;
                        mem_addr <= rd_base;
                        wr_a_q <= wr_base;
                        ph_q <= rd_len - 3'h1;
                        rd_exp_q <= rd_len;
                        if (reload_pend_q) begin
                            fwd_q <= reload_src;
                            cnt_q <= reload_q;
                        end
                    end
                end
                ST_READ: begin
                    if (ph_q == 3'h0) begin
                        state_q <= ST_WRITE;
                        mem_rd <= 1'b0;
                        mem_wr <= 1'b1;
                        mem_addr <= wr_a_q;
                        mem_wdata <= mem_rdata;
                        ph_q <= unit_len(unit_byte_q, bus_is_8bit, wr_a_q[0],
                                         wr_mem_type) - 3'h1;
                    end else begin
                        ph_q <= ph_q - 3'h1;
                    end
                end
                ST_WRITE: begin
                    if (ph_q == 3'h0) begin
                        state_q <= ST_IDLE;
                        mem_wr <= 1'b0;
                        fwd_q <= fwd_q + step;
                        cnt_q <= cnt_q - CW'(1);
                    end else begin
                        ph_q <= ph_q - 3'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Event status, write one to clear, set wins
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sts_q <= 2'h0;
            irq <= 1'b0;
        end else begin
            sts_q[`DMA_STS_UNIT] <= unit_end || (sts_q[`DMA_STS_UNIT] &&
                !(reg_wr && reg_addr == `DMA_OFF_STATUS && reg_wdata[`DMA_STS_UNIT]));
            sts_q[`DMA_STS_END] <= done || (sts_q[`DMA_STS_END] &&
                !(reg_wr && reg_addr == `DMA_OFF_STATUS && reg_wdata[`DMA_STS_END]));
            irq <= |(sts_q & mask_q);
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            reg_rdata <= 32'h0;
            case (reg_addr)
                `DMA_OFF_CTRL: begin
                    reg_rdata[`DMA_CTRL_EN] <= en_q;
                    reg_rdata[`DMA_CTRL_UNIT] <= unit_byte_q;
                    reg_rdata[`DMA_CTRL_SRCFWD] <= src_fwd_q;
                    reg_rdata[`DMA_CTRL_EXTRISE] <= ext_rise_q;
                    reg_rdata[`DMA_CTRL_TRIG_HI:`DMA_CTRL_TRIG_LO] <= trig_sel_q;
                end
                `DMA_OFF_REQ: reg_rdata[0] <= req_q;
                `DMA_OFF_SRC: reg_rdata[AW-1:0] <= src_q;
                `DMA_OFF_DST: reg_rdata[AW-1:0] <= dst_q;
                `DMA_OFF_RELOAD: reg_rdata[CW-1:0] <= reload_q;
                `DMA_OFF_FWD: reg_rdata[AW-1:0] <= fwd_q;
                `DMA_OFF_COUNT: reg_rdata[CW-1:0] <= cnt_q;
                `DMA_OFF_STATUS: reg_rdata[1:0] <= sts_q;
                `DMA_OFF_MASK: reg_rdata[1:0] <= mask_q;
                default: ;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    // Checking helpers
    logic [2:0] rd_run_q;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            rd_run_q <= 3'h0;
        end else begin
            rd_run_q <= mem_rd ? rd_run_q + 3'h1 : 3'h0;
        end
    end

    a_req_on_trigger: assert property (@(posedge clk_sys) disable iff (reset)
        trig_evt |=> req_q) else $error("request flag missed a trigger");

    a_req_sw_clear: assert property (@(posedge clk_sys) disable iff (reset)
        req_wr && !reg_wdata[0] && !trig_evt |=> !req_q)
        else $error("software zero did not clear request");

    a_req_sw_noset: assert property (@(posedge clk_sys) disable iff (reset)
        req_wr && reg_wdata[0] && !req_q && !trig_evt |=> !req_q)
        else $error("software one set request");

    a_start_clears: assert property (@(posedge clk_sys) disable iff (reset)
        start && !trig_evt |=> !req_q && mem_rd)
        else $error("request not cleared at transfer start");

    a_start_gated: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(mem_rd) |-> $past(en_q) && $past(req_q) && $past(bus_grant))
        else $error("transfer began without enable and request");

    a_reload_ptr: assert property (@(posedge clk_sys) disable iff (reset)
        start && reload_pend_q |=> fwd_q == $past(reload_src))
        else $error("forward pointer not reloaded");

    a_reload_count: assert property (@(posedge clk_sys) disable iff (reset)
        start && reload_pend_q |=> cnt_q == $past(reload_q))
        else $error("transfer counter not reloaded");

    a_restart_pend: assert property (@(posedge clk_sys) disable iff (reset)
        en_write |=> reload_pend_q)
        else $error("enable rewrite did not arm restart");

    a_read_length: assert property (@(posedge clk_sys) disable iff (reset)
        $fell(mem_rd) |-> rd_run_q == rd_exp_q && mem_wr)
        else $error("read phase length wrong");

    a_byte_unit: assert property (@(posedge clk_sys) disable iff (reset)
        start && unit_byte_q && rd_mem_type == MEM_FAST |=> mem_rd ##1 !mem_rd)
        else $error("byte unit read not one cycle");

endmodule

// File: dv/mem_model.sv
`timescale 1ns/1ps
module mem_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Engine side
    input wire logic bus_req,
    input wire logic [19:0] mem_addr,
    input wire logic mem_rd,
    input wire logic [3:0] grant_delay,
    // Answers
    output logic bus_grant,
    output logic [15:0] mem_rdata
);
    logic [3:0] wait_q;
    logic [15:0] last_q;
    // Grant after a chosen stall, held until the request drops
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wait_q <= 4'h0;
            bus_grant <= 1'b0;
        end else if (!bus_req) begin
            wait_q <= 4'h0;
            bus_grant <= 1'b0;
        end else if (wait_q >= grant_delay) begin
            bus_grant <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
    // Released data lines toggle so stale data never matches
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            last_q <= 16'h0;
        end else begin
            last_q <= mem_rdata;
        end
    end
    assign mem_rdata = mem_rd ? {4'h5, mem_addr[11:0]} : ~last_q;
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
`include "dma_defines.svh"
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [11:0] periph_irq_set = 12'h0;
    logic external_irq_input_zero = 1'b1;
    logic bus_is_8bit = 1'b0;
    logic [1:0] rd_mem_type = 2'h0;
    logic [1:0] wr_mem_type = 2'h0;
    logic [3:0] grant_delay = 4'h0;
    logic bus_grant, bus_req, mem_rd, mem_wr, irq;
    logic [15:0] mem_rdata, mem_wdata;
    logic [19:0] mem_addr, ra, wa;
    logic [7:0] rn, wn;
    logic [15:0] wd;
    logic [31:0] got;
    int bad_count = 0;
    int samples_checked = 0;
    always #2 clk_sys = ~clk_sys;
    dma_transfer_request_control i_dma_transfer_request_control (
        .clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .periph_irq_set, .external_irq_input_zero, .bus_grant, .bus_is_8bit,
        .rd_mem_type, .wr_mem_type, .mem_rdata, .bus_req, .mem_addr, .mem_rd,
        .mem_wr, .mem_wdata, .irq
    );
    mem_model i_mem_model (
        .clk_sys, .reset, .bus_req, .mem_addr, .mem_rd, .grant_delay, .bus_grant,
        .mem_rdata
    );
    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask
    task automatic pulse(input int n);
        @(posedge clk_sys);
        periph_irq_set <= 12'h1 << n;
        @(posedge clk_sys);
        periph_irq_set <= 12'h0;
    endtask
    // Counts read and write cycles of one unit, bounded
    task automatic run_unit();
        rn = 8'h0;
        wn = 8'h0;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk_sys);
            #1;
            if (mem_rd === 1'b1) begin
                if (rn == 8'h0) ra = mem_addr;
                rn++;
            end
            if (mem_wr === 1'b1) begin
                if (wn == 8'h0) wa = mem_addr;
                if (wn == 8'h0) wd = mem_wdata;
                wn++;
            end
            if (wn != 8'h0 && mem_wr !== 1'b1) break;
        end
        if (wn == 8'h0) begin
            bad_count++;
            summarize();
        end
    endtask
    task automatic xfer(input logic u, b8, input logic [1:0] rt, wt,
                        input logic [19:0] s, d, input logic [7:0] er, ew);
        @(posedge clk_sys);
        bus_is_8bit <= b8;
        rd_mem_type <= rt;
        wr_mem_type <= wt;
        wr(`DMA_OFF_SRC, {12'h0, s});
        wr(`DMA_OFF_DST, {12'h0, d});
        wr(`DMA_OFF_RELOAD, 32'h1);
        wr(`DMA_OFF_CTRL, {20'h0, `DMA_TRIG_SW, 5'h0, 1'b1, u, 1'b1});
        wr(`DMA_OFF_SWTRIG, 32'h1);
        run_unit();
        `CHK("read cycles", er, rn)
        `CHK("write cycles", ew, wn)
        `CHK("read addr", s, ra)
        `CHK("write addr", d, wa)
        if (!u) `CHK("data", {4'h5, s[11:0]}, wd)
        rd(`DMA_OFF_CTRL);
        `CHK("enable end", 1'b0, got[0])
        rd(`DMA_OFF_REQ);
        `CHK("req at start", 1'b0, got[0])
    endtask
    task automatic t_reset();
        wr(8'h30, 32'hffff_ffff);
        for (int a = 0; a <= 48; a += 4) begin
            rd(a[7:0]);
            `CHK("reset value", 32'h0, got)
        end
    endtask
    task automatic t_trig();
        wr(`DMA_OFF_CTRL, 32'h0000_0300);
        wr(`DMA_OFF_REQ, 32'h0);
        pulse(4);
        rd(`DMA_OFF_REQ);
        `CHK("other source", 1'b0, got[0])
        pulse(3);
        rd(`DMA_OFF_REQ);
        `CHK("periph req", 1'b1, got[0])
        wr(`DMA_OFF_REQ, 32'h1);
        rd(`DMA_OFF_REQ);
        `CHK("write one", 1'b1, got[0])
        for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            #1 `CHK("idle bus_req", 1'b0, bus_req)
        end
        wr(`DMA_OFF_REQ, 32'h0);
        rd(`DMA_OFF_REQ);
        `CHK("write zero", 1'b0, got[0])
        wr(`DMA_OFF_REQ, 32'h1);
        rd(`DMA_OFF_REQ);
        `CHK("write one idle", 1'b0, got[0])
        wr(`DMA_OFF_CTRL, 32'h0000_0e00);
        wr(`DMA_OFF_REQ, 32'h0);
        @(posedge clk_sys);
        external_irq_input_zero <= 1'b0;
        rd(`DMA_OFF_REQ);
        `CHK("falling edge", 1'b1, got[0])
        wr(`DMA_OFF_REQ, 32'h0);
        @(posedge clk_sys);
        external_irq_input_zero <= 1'b1;
        rd(`DMA_OFF_REQ);
        `CHK("rising edge", 1'b0, got[0])
        wr(`DMA_OFF_CTRL, 32'h0000_0e08);
        wr(`DMA_OFF_REQ, 32'h0);
        @(posedge clk_sys);
        external_irq_input_zero <= 1'b0;
        rd(`DMA_OFF_REQ);
        `CHK("fall in rise mode", 1'b0, got[0])
        @(posedge clk_sys);
        external_irq_input_zero <= 1'b1;
        rd(`DMA_OFF_REQ);
        `CHK("rise in rise mode", 1'b1, got[0])
        wr(`DMA_OFF_CTRL, 32'h0000_0f00);
        wr(`DMA_OFF_REQ, 32'h0);
        wr(`DMA_OFF_SWTRIG, 32'h1);
        rd(`DMA_OFF_REQ);
        `CHK("soft req", 1'b1, got[0])
        wr(`DMA_OFF_CTRL, 32'h0000_0f05);
        run_unit();
        `CHK("pending start", 8'h1, rn)
    endtask
    task automatic t_reload();
        @(posedge clk_sys);
        grant_delay <= 4'h5;
        wr(`DMA_OFF_SRC, 32'h300);
        wr(`DMA_OFF_DST, 32'h400);
        wr(`DMA_OFF_RELOAD, 32'h3);
        wr(`DMA_OFF_CTRL, 32'h0000_0f07);
        for (int n = 0; n < 2; n++) begin
            wr(`DMA_OFF_SWTRIG, 32'h1);
            run_unit();
            `CHK("unit addr", 20'h300 + n, ra)
            rd(`DMA_OFF_COUNT);
            `CHK("count", 32'h2 - n, got)
            rd(`DMA_OFF_FWD);
            `CHK("forward", 32'h301 + n, got)
        end
        wr(`DMA_OFF_CTRL, 32'h0000_0f07);
        wr(`DMA_OFF_SWTRIG, 32'h1);
        run_unit();
        `CHK("restart addr", 20'h300, ra)
        rd(`DMA_OFF_COUNT);
        `CHK("restart count", 32'h2, got)
        wr(`DMA_OFF_CTRL, 32'h0000_0f03);
        wr(`DMA_OFF_SWTRIG, 32'h1);
        run_unit();
        `CHK("dest addr", 20'h400, wa)
        rd(`DMA_OFF_FWD);
        `CHK("dest forward", 32'h401, got)
    endtask
    task automatic t_irq();
        rd(`DMA_OFF_STATUS);
        `CHK("status", 32'h3, got)
        `CHK("masked irq", 1'b0, irq)
        wr(`DMA_OFF_MASK, 32'h1);
        @(posedge clk_sys);
        #1 `CHK("irq on", 1'b1, irq)
        wr(`DMA_OFF_STATUS, 32'h1);
        @(posedge clk_sys);
        #1 `CHK("irq off", 1'b0, irq)
        rd(`DMA_OFF_STATUS);
        `CHK("status w1c", 32'h2, got)
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_trig();
        xfer(1'b1, 1'b0, 2'h0, 2'h0, 20'h100, 20'h201, 8'h1, 8'h1);
        xfer(1'b0, 1'b0, 2'h0, 2'h0, 20'h100, 20'h200, 8'h1, 8'h1);
        xfer(1'b0, 1'b0, 2'h1, 2'h2, 20'h101, 20'h200, 8'h4, 8'h3);
        xfer(1'b0, 1'b1, 2'h2, 2'h1, 20'h100, 20'h202, 8'h6, 8'h4);
        xfer(1'b1, 1'b1, 2'h1, 2'h2, 20'h105, 20'h207, 8'h2, 8'h3);
        xfer(1'b0, 1'b0, 2'h0, 2'h0, 20'h102, 20'h203, 8'h1, 8'h2);
        t_reload();
        t_irq();
        summarize();
    end
endmodule
